// File: rtl/codec_cfg.svh
`ifndef CODEC_CFG_SVH
`define CODEC_CFG_SVH

`define CLK_PERIOD_NS    4
`define BIT_PERIOD_NS    1000
`define SAMPLE_PERIOD_NS 125000
`define BIT_CYCLES       (`BIT_PERIOD_NS / `CLK_PERIOD_NS)
`define SAMPLE_CYCLES    (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)

`define IDX_LINE_VOL 8'hbb
`define IDX_HSET_VOL 8'hbc
`define IDX_DPATH    8'hc7
`define IDX_SYSMODE  8'hc8
`define IDX_CTEST    8'hc9
`define IDX_MTEST    8'hca
`define IDX_LINE_PCM 8'hcb
`define IDX_HSET_PCM 8'hcc
`define IDX_NONE     8'h00
`define REG_RESET    8'h00

`define VOL_DAC_MSB   7
`define VOL_DAC_LSB   6
`define VOL_ADC_BIT   3
`define DP_LINE_OVR   5
`define DP_LINE_SEL   4
`define DP_AMP_EN     2
`define DP_HSET_OVR   1
`define SM_MIC_SUPPLY 4

`define GAIN_LINE_LO  6'h07
`define GAIN_LINE_MID 6'h17
`define GAIN_LINE_HI  6'h23
`define GAIN_HSET_LO  6'h17
`define GAIN_HSET_HI  6'h23
`define GAIN_HSET_OVR 6'h07
`define GAIN_PREAMP   6'h0f

`define DEC_GAIN_MILLI 1436
`define DEC_GAIN_DIV   1000
`define PCM_POS_FS     16'h7fff
`define PCM_NEG_FS     16'h8000

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// File: rtl/codec_pkg.sv
package codec_pkg;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        arready;
		logic        aw_held;
		logic [11:0] aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [7:0]  line_vol;
		logic [7:0]  hset_vol;
		logic [7:0]  dpath;
		logic [7:0]  sysmode;
		logic [7:0]  ctest;
		logic [7:0]  mtest;
		logic [11:0] tick_cnt;
		logic        bit_tick;
		logic [15:0] gap;
		logic        seen;
	} top_state_t;

	typedef struct packed {
		logic [7:0]         bit_cnt;
		logic [7:0]         ones;
		logic signed [19:0] acc;
		logic [15:0]        tx_pcm_l;
		logic               loop;
		logic               mute;
		logic [15:0]        pcm;
		logic               pcm_valid;
		logic               tx_bit;
		logic [5:0]         rx_gain_db;
		logic [1:0]         dac_gain;
		logic               preamp_en;
		logic               sel_out;
	} chan_state_t;

endpackage

// File: rtl/codec_link_if.sv
`timescale 1ns/1ps
interface codec_link_if;
	logic        bit_tick;
	logic [7:0]  vol;
	logic        ovr;
	logic        amp_en;
	logic        sel;
	logic        loopback;
	logic        mute;
	logic        rx_bit;
	logic [15:0] tx_pcm;
	logic [15:0] pcm;
	logic        pcm_valid;
	logic        tx_bit;
	logic [5:0]  rx_gain_db;
	logic [1:0]  dac_gain;
	logic        preamp_en;
	logic        sel_out;

	modport top (output bit_tick, vol, ovr, amp_en, sel, loopback, mute, rx_bit, tx_pcm,
		input pcm, pcm_valid, tx_bit, rx_gain_db, dac_gain, preamp_en, sel_out);
	modport chan (input bit_tick, vol, ovr, amp_en, sel, loopback, mute, rx_bit, tx_pcm,
		output pcm, pcm_valid, tx_bit, rx_gain_db, dac_gain, preamp_en, sel_out);
endinterface

// File: rtl/codec_channel.sv
`timescale 1ns/1ps
`include "codec_cfg.svh"
module codec_channel #(
	parameter bit HANDSET   = 1'b0,
	parameter int DEC_RATIO = 125
) (
	input wire logic   clk,
	input wire logic   rst,
	codec_link_if.chan lnk
);
	localparam int POS_LIM = int'(signed'(`PCM_POS_FS));
	localparam int NEG_LIM = int'(signed'(`PCM_NEG_FS));
	localparam int DEC_K   = (POS_LIM * `DEC_GAIN_MILLI) / (`DEC_GAIN_DIV * DEC_RATIO);
	localparam logic [7:0]  LAST = 8'(DEC_RATIO - 1);
	localparam logic [7:0]  FULL = 8'(DEC_RATIO);
	localparam logic signed [19:0] FB_POS = 20'(POS_LIM);
	localparam logic signed [19:0] FB_NEG = 20'(NEG_LIM);

	codec_pkg::chan_state_t s;
	codec_pkg::chan_state_t n;
	logic                   in_bit;
	logic [7:0]             ones_new;
	logic signed [19:0]     acc_new;

	// Boxcar over one sample, then fixed gain; clips like the real filter
	function automatic logic [15:0] dec_scale(input logic [7:0] ones);
		int v;
		v = (2 * int'(ones) - DEC_RATIO) * DEC_K;
		if (v > POS_LIM)
			return `PCM_POS_FS;
		if (v < NEG_LIM)
			return `PCM_NEG_FS;
		return 16'(v);
	endfunction

	always_comb begin
		n = s;
		n.pcm_valid = 1'b0;
		in_bit = s.loop ? s.tx_bit : lnk.rx_bit;
		ones_new = s.ones + {7'h00, in_bit};
		acc_new = s.acc + {{4{s.tx_pcm_l[15]}}, s.tx_pcm_l} - (s.tx_bit ? FB_POS : FB_NEG);
		if (lnk.bit_tick) begin
			n.acc = acc_new;
			n.tx_bit = ~acc_new[19];
			if (s.bit_cnt == LAST) begin
				n.bit_cnt = 8'h00;
				n.ones = 8'h00;
				n.pcm = dec_scale(ones_new);
				n.pcm_valid = 1'b1;
				// Settings move only here, so a sample never mixes two gains
				n.tx_pcm_l = lnk.mute ? 16'h0000 : lnk.tx_pcm;
				n.loop = lnk.loopback;
				n.mute = lnk.mute;
				n.sel_out = lnk.sel;
				n.dac_gain = lnk.vol[`VOL_DAC_MSB:`VOL_DAC_LSB];
				if (HANDSET) begin
					n.preamp_en = lnk.amp_en & ~lnk.ovr;
					if (lnk.ovr)
						n.rx_gain_db = `GAIN_HSET_OVR;
					else
						n.rx_gain_db = (lnk.vol[`VOL_ADC_BIT] ? `GAIN_HSET_HI : `GAIN_HSET_LO)
							+ (lnk.amp_en ? `GAIN_PREAMP : 6'h00);
				end else begin
					n.preamp_en = 1'b0;
					if (lnk.ovr)
						n.rx_gain_db = `GAIN_LINE_HI;
					else
						n.rx_gain_db = lnk.vol[`VOL_ADC_BIT] ? `GAIN_LINE_MID : `GAIN_LINE_LO;
				end
			end else begin
				n.bit_cnt = s.bit_cnt + 8'h01;
				n.ones = ones_new;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			s <= '0;
		else
			s <= n;
	end

	assign lnk.pcm        = s.pcm;
	assign lnk.pcm_valid  = s.pcm_valid;
	assign lnk.tx_bit     = s.tx_bit;
	assign lnk.rx_gain_db = s.rx_gain_db;
	assign lnk.dac_gain   = s.dac_gain;
	assign lnk.preamp_en  = s.preamp_en;
	assign lnk.sel_out    = s.sel_out;

	sequence s_sample_end;
		lnk.bit_tick && s.bit_cnt == LAST;
	endsequence

	property p_sample_pulse;
		@(posedge clk) disable iff (rst) s_sample_end |=> lnk.pcm_valid ##1 !lnk.pcm_valid;
	endproperty
	a_sample_pulse: assert property (p_sample_pulse) else $error("sample pulse wrong");

	property p_full_scale;
		@(posedge clk) disable iff (rst) s_sample_end and (ones_new == FULL) |=> lnk.pcm == `PCM_POS_FS;
	endproperty
	a_full_scale: assert property (p_full_scale) else $error("all ones not full scale");

	property p_gain_hold;
		@(posedge clk) disable iff (rst)
			!lnk.pcm_valid |-> $stable(lnk.rx_gain_db) && $stable(lnk.dac_gain);
	endproperty
	a_gain_hold: assert property (p_gain_hold) else $error("gain moved mid sample");

	property p_shaper_ones;
		@(posedge clk) disable iff (rst)
			lnk.bit_tick && s.tx_pcm_l == `PCM_POS_FS && s.tx_bit && !s.acc[19] |=> lnk.tx_bit;
	endproperty
	a_shaper_ones: assert property (p_shaper_ones) else $error("full scale not ones");

	property p_override_gain;
		@(posedge clk) disable iff (rst) lnk.pcm_valid && $past(lnk.ovr) |->
			lnk.rx_gain_db == (HANDSET ? `GAIN_HSET_OVR : `GAIN_LINE_HI) && !lnk.preamp_en;
	endproperty
	a_override_gain: assert property (p_override_gain) else $error("override ignored");

	property p_preamp;
		@(posedge clk) disable iff (rst) lnk.pcm_valid && HANDSET && !$past(lnk.ovr)
			&& $past(lnk.amp_en) && !$past(lnk.vol[`VOL_ADC_BIT])
			|-> lnk.rx_gain_db == `GAIN_HSET_LO + `GAIN_PREAMP;
	endproperty
	a_preamp: assert property (p_preamp) else $error("preamp gain wrong");
endmodule

// File: rtl/dual_speech_codec_control.sv
`timescale 1ns/1ps
`include "codec_cfg.svh"
module dual_speech_codec_control #(
	parameter int BIT_CYCLES    = `BIT_CYCLES,
	parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [11:0]       awaddr,
	input  wire logic              awvalid,
	output wire logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output wire logic              wready,
	output wire logic [1:0]        bresp,
	output wire logic              bvalid,
	input  wire logic              bready,
	input  wire logic [11:0]       araddr,
	input  wire logic              arvalid,
	output wire logic              arready,
	output wire logic [31:0]       rdata,
	output wire logic [1:0]        rresp,
	output wire logic              rvalid,
	input  wire logic              rready,
	input  wire logic [1:0]        rx_bit,
	input  wire logic [1:0][15:0]  tx_pcm,
	output wire logic [1:0]        tx_bit,
	output wire logic [1:0][15:0]  rx_pcm,
	output wire logic [1:0]        rx_pcm_valid,
	output wire logic [1:0][5:0]   rx_gain_db,
	output wire logic [1:0][1:0]   dac_gain,
	output wire logic              preamp_enable,
	output wire logic              line_input_select,
	output wire logic              mic_supply_enable
);
	localparam int          DEC_RATIO = SAMPLE_CYCLES / BIT_CYCLES;
	localparam logic [11:0] TICK_LAST = 12'(BIT_CYCLES - 1);
	localparam logic [15:0] GAP_LAST  = 16'(SAMPLE_CYCLES - 1);

	codec_pkg::top_state_t s;
	codec_pkg::top_state_t n;
	logic                  wr_go;

	// Out-of-window addresses fold onto an unmapped index
	function automatic logic [7:0] reg_idx(input logic [11:0] a);
		return (a[11:10] == 2'h0 && a[1:0] == 2'h0) ? a[9:2] : `IDX_NONE;
	endfunction

	function automatic logic mapped(input logic [7:0] idx);
		case (idx)
			`IDX_LINE_VOL, `IDX_HSET_VOL, `IDX_DPATH, `IDX_SYSMODE,
			`IDX_CTEST, `IDX_MTEST, `IDX_LINE_PCM, `IDX_HSET_PCM: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	codec_link_if lnk [2] ();

	always_comb begin
		n = s;
		n.bit_tick = 1'b0;
		if (s.tick_cnt == TICK_LAST) begin
			n.tick_cnt = 12'h000;
			n.bit_tick = 1'b1;
		end else begin
			n.tick_cnt = s.tick_cnt + 12'h001;
		end
		if (lnk[0].pcm_valid) begin
			n.gap = 16'h0000;
			n.seen = 1'b1;
		end else begin
			n.gap = s.gap + 16'h0001;
		end

		if (s.awready && awvalid) begin
			n.aw_held = 1'b1;
			n.aw_addr = awaddr;
		end
		if (s.wready && wvalid) begin
			n.w_held = 1'b1;
			n.w_data = wdata;
			n.w_strb = wstrb;
		end
		if (s.bvalid && bready)
			n.bvalid = 1'b0;
		wr_go = s.aw_held && s.w_held && !s.bvalid;
		if (wr_go) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = mapped(reg_idx(s.aw_addr)) ? `RESP_OKAY : `RESP_SLVERR;
			// Writable registers are one byte wide; only lane 0 carries them
			if (s.w_strb[0]) begin
				case (reg_idx(s.aw_addr))
					`IDX_LINE_VOL: n.line_vol = s.w_data[7:0];
					`IDX_HSET_VOL: n.hset_vol = s.w_data[7:0];
					`IDX_DPATH:    n.dpath = s.w_data[7:0];
					`IDX_SYSMODE:  n.sysmode = s.w_data[7:0];
					`IDX_CTEST:    n.ctest = s.w_data[7:0];
					`IDX_MTEST:    n.mtest = s.w_data[7:0];
					default: ;
				endcase
			end
		end
		n.awready = !n.aw_held;
		n.wready = !n.w_held;

		if (s.rvalid && rready)
			n.rvalid = 1'b0;
		if (s.arready && arvalid) begin
			n.rvalid = 1'b1;
			n.rresp = `RESP_OKAY;
			n.rdata = 32'h0000_0000;
			case (reg_idx(araddr))
				`IDX_LINE_VOL: n.rdata[7:0] = s.line_vol;
				`IDX_HSET_VOL: n.rdata[7:0] = s.hset_vol;
				`IDX_DPATH:    n.rdata[7:0] = s.dpath;
				`IDX_SYSMODE:  n.rdata[7:0] = s.sysmode;
				`IDX_CTEST:    n.rdata[7:0] = s.ctest;
				`IDX_MTEST:    n.rdata[7:0] = s.mtest;
				`IDX_LINE_PCM: n.rdata[15:0] = lnk[0].pcm;
				`IDX_HSET_PCM: n.rdata[15:0] = lnk[1].pcm;
				default:       n.rresp = `RESP_SLVERR;
			endcase
		end
		n.arready = !n.rvalid;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.line_vol <= `REG_RESET;
			s.hset_vol <= `REG_RESET;
			s.dpath <= `REG_RESET;
			s.ctest <= `REG_RESET;
			s.mtest <= `REG_RESET;
		end else begin
			s <= n;
		end
	end

	// Index 0 is the line codec, index 1 the handset codec
	for (genvar i = 0; i < 2; i++) begin : g_codec
		codec_channel #(
			.HANDSET   (i == 1),
			.DEC_RATIO (DEC_RATIO)
		) u_chan (
			.clk (clk),
			.rst (rst),
			.lnk (lnk[i])
		);
		assign lnk[i].bit_tick = s.bit_tick;
		assign lnk[i].vol = (i == 0) ? s.line_vol : s.hset_vol;
		assign lnk[i].ovr = (i == 0) ? s.dpath[`DP_LINE_OVR] : s.dpath[`DP_HSET_OVR];
		assign lnk[i].amp_en = (i == 1) && s.dpath[`DP_AMP_EN];
		assign lnk[i].sel = (i == 0) && s.dpath[`DP_LINE_SEL];
		assign lnk[i].loopback = s.ctest[i];
		assign lnk[i].mute = s.mtest[i];
		assign lnk[i].rx_bit = rx_bit[i];
		assign lnk[i].tx_pcm = tx_pcm[i];
		assign tx_bit[i] = lnk[i].tx_bit;
		assign rx_pcm[i] = lnk[i].pcm;
		assign rx_pcm_valid[i] = lnk[i].pcm_valid;
		assign rx_gain_db[i] = lnk[i].rx_gain_db;
		assign dac_gain[i] = lnk[i].dac_gain;
	end

	assign awready           = s.awready;
	assign wready            = s.wready;
	assign bvalid            = s.bvalid;
	assign bresp             = s.bresp;
	assign arready           = s.arready;
	assign rvalid            = s.rvalid;
	assign rdata             = s.rdata;
	assign rresp             = s.rresp;
	assign preamp_enable     = lnk[1].preamp_en;
	assign line_input_select = lnk[0].sel_out;
	assign mic_supply_enable = s.sysmode[`SM_MIC_SUPPLY];

	sequence s_sysmode_write;
		wr_go && reg_idx(s.aw_addr) == `IDX_SYSMODE && s.w_strb[0];
	endsequence

	property p_mic_write;
		@(posedge clk) disable iff (rst)
			s_sysmode_write |=> mic_supply_enable == $past(s.w_data[`SM_MIC_SUPPLY]);
	endproperty
	a_mic_write: assert property (p_mic_write) else $error("mic supply not following write");

	property p_line_sel;
		@(posedge clk) disable iff (rst)
			rx_pcm_valid[0] |-> line_input_select == $past(s.dpath[`DP_LINE_SEL]);
	endproperty
	a_line_sel: assert property (p_line_sel) else $error("line input select wrong");

	property p_vol_reset;
		@(posedge clk) disable iff (rst)
			$past(rst) |-> s.line_vol == `REG_RESET && s.hset_vol == `REG_RESET;
	endproperty
	a_vol_reset: assert property (p_vol_reset) else $error("volume not cleared");

	property p_test_reset;
		@(posedge clk) disable iff (rst)
			$past(rst) |-> s.ctest == `REG_RESET && s.mtest == `REG_RESET;
	endproperty
	a_test_reset: assert property (p_test_reset) else $error("test regs not normal");

	property p_rate;
		@(posedge clk) disable iff (rst) rx_pcm_valid[0] && s.seen |-> s.gap == GAP_LAST;
	endproperty
	a_rate: assert property (p_rate) else $error("sample period wrong");

	property p_dac_gain;
		@(posedge clk) disable iff (rst)
			rx_pcm_valid[1] |-> dac_gain[1] == $past(s.hset_vol[`VOL_DAC_MSB:`VOL_DAC_LSB]);
	endproperty
	a_dac_gain: assert property (p_dac_gain) else $error("dac gain wrong");

	property p_write_answer;
		@(posedge clk) disable iff (rst)
			wr_go |=> bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write not answered");

	property p_write_refused;
		@(posedge clk) disable iff (rst)
			wr_go && !mapped(reg_idx(s.aw_addr)) |=> bresp == `RESP_SLVERR;
	endproperty
	a_write_refused: assert property (p_write_refused) else $error("bad write accepted");

	property p_read_answer;
		@(posedge clk) disable iff (rst)
			arvalid && arready |=> rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");

	property p_read_refused;
		@(posedge clk) disable iff (rst)
			arvalid && arready && !mapped(reg_idx(araddr))
			|=> rvalid && rresp == `RESP_SLVERR && rdata == 32'h0000_0000;
	endproperty
	a_read_refused: assert property (p_read_refused) else $error("bad read accepted");

	property p_line_vol_write;
		@(posedge clk) disable iff (rst)
			wr_go && s.w_strb[0] && reg_idx(s.aw_addr) == `IDX_LINE_VOL
			|=> s.line_vol == $past(s.w_data[7:0]);
	endproperty
	a_line_vol_write: assert property (p_line_vol_write) else $error("line volume lost");

	property p_hset_vol_write;
		@(posedge clk) disable iff (rst)
			wr_go && s.w_strb[0] && reg_idx(s.aw_addr) == `IDX_HSET_VOL
			|=> s.hset_vol == $past(s.w_data[7:0]);
	endproperty
	a_hset_vol_write: assert property (p_hset_vol_write) else $error("handset volume lost");

	property p_dpath_write;
		@(posedge clk) disable iff (rst)
			wr_go && s.w_strb[0] && reg_idx(s.aw_addr) == `IDX_DPATH
			|=> s.dpath == $past(s.w_data[7:0]);
	endproperty
	a_dpath_write: assert property (p_dpath_write) else $error("data path control lost");

	property p_ctest_write;
		@(posedge clk) disable iff (rst)
			wr_go && s.w_strb[0] && reg_idx(s.aw_addr) == `IDX_CTEST
			|=> s.ctest == $past(s.w_data[7:0]);
	endproperty
	a_ctest_write: assert property (p_ctest_write) else $error("codec test reg lost");

	property p_mtest_write;
		@(posedge clk) disable iff (rst)
			wr_go && s.w_strb[0] && reg_idx(s.aw_addr) == `IDX_MTEST
			|=> s.mtest == $past(s.w_data[7:0]);
	endproperty
	a_mtest_write: assert property (p_mtest_write) else $error("modulator test reg lost");

	property p_regs_quiet;
		@(posedge clk) disable iff (rst)
			!wr_go |=> $stable(s.line_vol) && $stable(s.hset_vol) && $stable(s.dpath);
	endproperty
	a_regs_quiet: assert property (p_regs_quiet) else $error("settings moved unwritten");

	property p_pcm_hold;
		@(posedge clk) disable iff (rst)
			!rx_pcm_valid[0] |-> $stable(rx_pcm[0]);
	endproperty
	a_pcm_hold: assert property (p_pcm_hold) else $error("pcm moved between samples");

	property p_tx_hold;
		@(posedge clk) disable iff (rst)
			!$past(s.bit_tick) |-> $stable(tx_bit);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("bitstream moved off tick");
endmodule

// File: tb/far_side_model.sv
`timescale 1ns/1ps
module far_side_model (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic [1:0][1:0] pattern,
	output logic      [1:0]      rx_bit
);
	// Pattern 0 zeroes, 1 ones, 2 toggles each clock; odd bit period gives half density
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (rst || pattern[i] == 2'h0) begin
				rx_bit[i] <= 1'b0;
			end else if (pattern[i] == 2'h1) begin
				rx_bit[i] <= 1'b1;
			end else begin
				rx_bit[i] <= ~rx_bit[i];
			end
		end
	end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
	localparam logic [11:0] LVOL = 12'h2ec;
	localparam logic [11:0] HVOL = 12'h2f0;
	localparam logic [11:0] DPATH = 12'h31c;
	localparam logic [11:0] SMODE = 12'h320;
	localparam logic [11:0] CTEST = 12'h324;
	localparam logic [11:0] MTEST = 12'h328;
	localparam logic [11:0] LPCM = 12'h32c;
	localparam logic [5:0][11:0] REGS = {MTEST, CTEST, SMODE, DPATH, HVOL, LVOL};
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic preamp_enable, line_input_select, mic_supply_enable;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rx_bit, tx_bit, rx_pcm_valid, r;
	logic [1:0][15:0] tx_pcm, rx_pcm;
	logic [1:0][5:0] rx_gain_db;
	logic [1:0][1:0] dac_gain, pattern;
	logic [5:0] pl, ph;
	int failures, n_compared, cyc, n;

	// Bit period 5 keeps the toggling pattern at exactly half density
	dual_speech_codec_control #(.BIT_CYCLES(5), .SAMPLE_CYCLES(50)) i_dual_speech_codec_control (
		.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .rx_bit, .tx_pcm, .tx_bit, .rx_pcm, .rx_pcm_valid, .rx_gain_db,
		.dac_gain, .preamp_enable, .line_input_select, .mic_supply_enable);

	far_side_model i_far_side_model (.clk, .rst, .pattern, .rx_bit);

	always #2 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end

	task wrap_up();
		if (failures == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er);
	endtask

	task rd(input logic [11:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	task wait_pulse(input int k);
		repeat (k) begin
			do @(posedge clk); while (rx_pcm_valid[0] !== 1'b1);
		end
	endtask

	task t_reset();
		for (int i = 0; i < 6; i++) begin
			rd(REGS[i]);
			chk(d, 0);
			chk(r, 0);
		end
		chk(mic_supply_enable, 0);
	endtask

	task t_refuse();
		rd(12'h000);
		chk(r, 2);
		chk(d, 0);
		wr(12'h004, 32'hff, 2'h2);
		wr(LPCM, 32'hff, 2'h0);
	endtask

	task t_rate();
		wait_pulse(1);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rx_pcm_valid[0] !== 1'b1);
		chk(n, 50);
		chk(rx_pcm_valid, 2'h3);
	endtask

	task t_pcm();
		pattern <= {2'h0, 2'h1};
		wait_pulse(3);
		chk(rx_pcm[0], 16'h7fff);
		chk(rx_pcm[1], 16'h8000);
		rd(LPCM);
		chk(d[15:0], 16'h7fff);
		pattern <= {2'h2, 2'h2};
		wait_pulse(3);
		chk(rx_pcm, 32'h0);
	endtask

	task apply(input logic [7:0] l, input logic [7:0] h, input logic [7:0] dp,
		input logic [5:0] gl, input logic [5:0] gh, input logic [1:0] dl,
		input logic [1:0] dh, input logic sel, input logic mic_preamplifier);
		wait_pulse(1);
		wr(LVOL, {24'h0, l}, 2'h0);
		wr(HVOL, {24'h0, h}, 2'h0);
		wr(DPATH, {24'h0, dp}, 2'h0);
		chk(rx_gain_db, {ph, pl});
		wait_pulse(1);
		chk(rx_gain_db[0], gl);
		chk(rx_gain_db[1], gh);
		chk(dac_gain, {dh, dl});
		chk(line_input_select, sel);
		chk(preamp_enable, mic_preamplifier);
		pl = gl;
		ph = gh;
	endtask

	task t_mic();
		wr(SMODE, 32'h10, 2'h0);
		@(posedge clk);
		chk(mic_supply_enable, 1);
		wr(SMODE, 32'hef, 2'h0);
		@(posedge clk);
		chk(mic_supply_enable, 0);
	endtask

	task t_tx();
		tx_pcm <= {16'h8000, 16'h7fff};
		wait_pulse(3);
		repeat (50) begin
			@(posedge clk);
			chk(tx_bit, 2'h1);
		end
		// Muted line shaper idles near half density
		wr(MTEST, 32'h1, 2'h0);
		wait_pulse(3);
		n = 0;
		repeat (50) begin
			@(posedge clk);
			n += tx_bit[0];
		end
		chk(n >= 20 && n <= 30, 1);
		chk(tx_bit[1], 0);
		wr(MTEST, 32'h0, 2'h0);
	endtask

	task t_loop();
		pattern <= {2'h0, 2'h0};
		wr(CTEST, 32'h1, 2'h0);
		wait_pulse(3);
		chk(rx_pcm[0], 16'h7fff);
		rd(CTEST);
		chk(d, 1);
		wr(CTEST, 32'h0, 2'h0);
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		tx_pcm = '0;
		pattern = '0;
		{failures, n_compared, cyc} = '0;
		pl = 6'd7;
		ph = 6'd23;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_refuse();
		t_rate();
		t_pcm();
		apply(8'h00, 8'h00, 8'h00, 6'd7, 6'd23, 2'h0, 2'h0, 1'b0, 1'b0);
		apply(8'h48, 8'h88, 8'h04, 6'd23, 6'd50, 2'h1, 2'h2, 1'b0, 1'b1);
		apply(8'hc0, 8'h40, 8'h30, 6'd35, 6'd23, 2'h3, 2'h1, 1'b1, 1'b0);
		apply(8'h08, 8'h08, 8'h06, 6'd23, 6'd7, 2'h0, 2'h0, 1'b0, 1'b0);
		apply(8'h00, 8'h00, 8'h04, 6'd7, 6'd38, 2'h0, 2'h0, 1'b0, 1'b1);
		t_mic();
		t_tx();
		t_loop();
		wr(SMODE, 32'h10, 2'h0);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		wrap_up();
	end
endmodule
